// [design/tx_crc_defines.svh]
// register offsets, field positions, reset values and constants of the transmit control block
// assumes inclusion by bare name from the block and the bench
`ifndef TX_CRC_DEFINES_SVH
`define TX_CRC_DEFINES_SVH

`define OFF_DRIVER_MODE      8'h28
`define OFF_CARRIER_AMP      8'h29
`define OFF_MOD_CTRL         8'h2a
`define OFF_LOAD_OVERSHOOT   8'h2b
`define OFF_CHECK_CFG        8'h2c

`define RST_REG              8'h00

`define BIT_OUT2_INVERT      7
`define BIT_OUT1_INVERT      6
`define BIT_PINS_ON          3
`define MSB_OUTPUT_STYLE     2
`define MSB_CARRIER_TRIM     7
`define LSB_CARRIER_TRIM     6
`define MSB_RESIDUAL         4
`define MSB_EXTRA_MOD        7
`define LSB_EXTRA_MOD        4
`define BIT_CARRIER_FULL     3
`define BIT_MOD_INVERT       2
`define MSB_MOD_SOURCE       1
`define MSB_FIRST_PHASE      7
`define LSB_FIRST_PHASE      4
`define MSB_LOAD_TRIM        3
`define MSB_START_SEL        6
`define LSB_START_SEL        4
`define MSB_WIDTH_SEL        3
`define LSB_WIDTH_SEL        2
`define BIT_COMPLEMENT       1
`define BIT_APPEND_ON        0

`define MASK_DRIVER_MODE     8'hcf
`define MASK_CARRIER_AMP     8'hdf
`define MASK_CHECK_CFG       8'h7f

`define DROP_MV_0            10'h064
`define DROP_MV_1            10'h0fa
`define DROP_MV_2            10'h1f4
`define DROP_MV_3            10'h3e8

`define POLY_5               16'h0009
`define POLY_8               16'h001d
`define POLY_16              16'h1021

`define PRESET16_0           16'h0000
`define PRESET16_1           16'h6363
`define PRESET16_2           16'ha671
`define PRESET16_3           16'hfffe
`define PRESET16_7           16'hffff
`define PRESET8_0            16'h0000
`define PRESET8_1            16'h0012
`define PRESET8_2            16'h00bf
`define PRESET8_3            16'h00fd
`define PRESET8_7            16'h00ff
`define PRESET5_0            16'h0000
`define PRESET5_1            16'h0012
`define PRESET5_7            16'h001f

`endif

// [design/tx_crc_pkg.sv]
// types of the transmit control block
// uses nothing from the defines header and does not include it
package tx_crc_pkg;
  typedef enum logic [1:0] {ST_IDLE, ST_DATA, ST_CHECK} tx_state_t;
  typedef enum logic [1:0] {CK_5, CK_8, CK_16, CK_RSVD} check_width_t;
  typedef enum logic [1:0] {SRC_NONE, SRC_ENVELOPE, SRC_SERIAL, SRC_RSVD} mod_source_t;

  typedef struct packed {
    logic [7:0] driver_mode_ctrl;
    logic [7:0] carrier_amplitude_ctrl;
    logic [7:0] modulation_ctrl;
    logic [7:0] load_overshoot_ctrl;
    logic [7:0] tx_check_code_cfg;
  } tx_regs_t;

  typedef struct packed {
    tx_regs_t   regs;
    logic [7:0] rdata;
    tx_state_t  state;
    logic [7:0] shift;
    logic [2:0] bit_cnt;
    logic [15:0] crc;
    logic [3:0] crc_cnt;
    logic       ready;
    logic       envelope;
    logic       sync_a;
    logic       sync_b;
    logic       mod_prev;
    logic [3:0] os_cnt;
    logic [1:0] pins;
    logic [9:0] drop_mv;
    logic       busy;
    logic       os_active;
  } tx_ctrl_state_t;
endpackage : tx_crc_pkg

// [design/tx_crc_and_modulation_ctrl.sv]
// transmit driver settings, modulation select and check-code append for a contactless reader
// assumes a framer on the same clock feeding bytes, and an asynchronous serial modulation pin
//
// Summary of operation
// - bit 7 inverts second antenna pin
// - bit 6 inverts first antenna pin
// - enable bit drives both antenna pins
// - amplitude code selects 100/250/500/1000 mV drop
// - full-carrier bit overrides amplitude reduction
// - residual carrier from bits 4..0
// - bits 7..4 give extra modulation length
// - bit 2 inverts selected modulation
// - source none, envelope or serial input
// - load bits 7..4 first phase overshoot
// - load bits 3..0 trim load current
// - enable bit appends check code
// - complement bit inverts appended code
// - width select 5, 8 or 16 bits
// - start select in bits 6..4
// - fixed start values per code and width
// - code 6 loads stored user start value
// - bytes sent lsb first, code follows
`timescale 1ns/1ns
`default_nettype none
`include "tx_crc_defines.svh"

module tx_crc_and_modulation_ctrl
  import tx_crc_pkg::*;
(
  input  wire logic        ref_clk_in,
  input  wire logic        rst_in,
  input  wire logic [7:0]  reg_addr_in,
  input  wire logic [7:0]  reg_wdata_in,
  input  wire logic        reg_wr_in,
  input  wire logic        reg_rd_in,
  output logic      [7:0]  reg_rdata_out,
  input  wire logic [7:0]  tx_byte_in,
  input  wire logic        tx_byte_valid_in,
  output logic             tx_byte_ready_out,
  output logic             tx_busy_out,
  input  wire logic [15:0] user_preset_in,
  input  wire logic        external_serial_input_in,
  output logic             antenna_out_a_out,
  output logic             antenna_out_b_out,
  output logic      [2:0]  driver_output_style_out,
  output logic             carrier_full_out,
  output logic      [9:0]  carrier_drop_mv_out,
  output logic      [4:0]  residual_carrier_out,
  output logic      [3:0]  extra_mod_length_out,
  output logic             overshoot_active_out,
  output logic      [3:0]  first_phase_overshoot_out,
  output logic      [3:0]  load_current_trim_out
);

  tx_ctrl_state_t st;
  tx_ctrl_state_t next_st;

  // top bit index of the selected check width
  function automatic logic [3:0] check_top(input logic [1:0] w);
    case (check_width_t'(w))
      CK_5:    check_top = 4'h4;
      CK_8:    check_top = 4'h7;
      default: check_top = 4'hf;
    endcase
  endfunction : check_top

  // one serial step of the check register
  function automatic logic [15:0] check_step(input logic [15:0] c, input logic b, input logic [1:0] w);
    logic [15:0] poly;
    logic [15:0] mask;
    logic        fb;
    poly = `POLY_16;
    mask = 16'hffff;
    case (check_width_t'(w))
      CK_5: begin
        poly = `POLY_5;
        mask = 16'h001f;
      end
      CK_8: begin
        poly = `POLY_8;
        mask = 16'h00ff;
      end
      default: begin
        poly = `POLY_16;
        mask = 16'hffff;
      end
    endcase
    fb = c[check_top(w)] ^ b;
    check_step = ({c[14:0], 1'b0} ^ (fb ? poly : 16'h0000)) & mask;
  endfunction : check_step

  // start value by selector and width; undefined codes load zero
  function automatic logic [15:0] check_preset(input logic [2:0] s, input logic [1:0] w,
                                               input logic [15:0] user);
    logic [15:0] v;
    v = 16'h0000;
    case (s)
      3'h1: v = (w == 2'h2) ? `PRESET16_1 : (w == 2'h1) ? `PRESET8_1 : `PRESET5_1;
      3'h2: v = (w == 2'h2) ? `PRESET16_2 : (w == 2'h1) ? `PRESET8_2 : 16'h0000;
      3'h3: v = (w == 2'h2) ? `PRESET16_3 : (w == 2'h1) ? `PRESET8_3 : 16'h0000;
      3'h6: v = (w == 2'h2) ? user : (w == 2'h1) ? {8'h00, user[7:0]} : {11'h000, user[4:0]};
      3'h7: v = (w == 2'h2) ? `PRESET16_7 : (w == 2'h1) ? `PRESET8_7 : `PRESET5_7;
      default: v = 16'h0000;
    endcase
    check_preset = v;
  endfunction : check_preset

  logic [2:0] start_sel;
  logic [1:0] width_sel;
  logic       append_on;
  logic       complement;
  logic       mod_src_bit;
  logic       mod_now;
  logic [1:0] pin_inv;
  logic       take_byte;
  logic [1:0] next_pin;

  always_comb begin
    start_sel  = st.regs.tx_check_code_cfg[`MSB_START_SEL:`LSB_START_SEL];
    width_sel  = st.regs.tx_check_code_cfg[`MSB_WIDTH_SEL:`LSB_WIDTH_SEL];
    append_on  = st.regs.tx_check_code_cfg[`BIT_APPEND_ON];
    complement = st.regs.tx_check_code_cfg[`BIT_COMPLEMENT];
    pin_inv    = {st.regs.driver_mode_ctrl[`BIT_OUT2_INVERT], st.regs.driver_mode_ctrl[`BIT_OUT1_INVERT]};
    case (mod_source_t'(st.regs.modulation_ctrl[`MSB_MOD_SOURCE:0]))
      SRC_ENVELOPE: mod_src_bit = st.envelope;
      SRC_SERIAL:   mod_src_bit = st.sync_b;
      default:      mod_src_bit = 1'b0;
    endcase
    mod_now   = mod_src_bit ^ st.regs.modulation_ctrl[`BIT_MOD_INVERT];
    take_byte = tx_byte_valid_in && st.ready;
  end

  always_comb begin
    next_st = st;
    next_st.rdata = 8'h00;
    if (reg_wr_in) begin
      case (reg_addr_in)
        `OFF_DRIVER_MODE:    next_st.regs.driver_mode_ctrl = reg_wdata_in & `MASK_DRIVER_MODE;
        `OFF_CARRIER_AMP:    next_st.regs.carrier_amplitude_ctrl = reg_wdata_in & `MASK_CARRIER_AMP;
        `OFF_MOD_CTRL:       next_st.regs.modulation_ctrl = reg_wdata_in;
        `OFF_LOAD_OVERSHOOT: next_st.regs.load_overshoot_ctrl = reg_wdata_in;
        `OFF_CHECK_CFG:      next_st.regs.tx_check_code_cfg = reg_wdata_in & `MASK_CHECK_CFG;
        default:             next_st.regs = st.regs;
      endcase
    end
    if (reg_rd_in) begin
      case (reg_addr_in)
        `OFF_DRIVER_MODE:    next_st.rdata = st.regs.driver_mode_ctrl;
        `OFF_CARRIER_AMP:    next_st.rdata = st.regs.carrier_amplitude_ctrl;
        `OFF_MOD_CTRL:       next_st.rdata = st.regs.modulation_ctrl;
        `OFF_LOAD_OVERSHOOT: next_st.rdata = st.regs.load_overshoot_ctrl;
        `OFF_CHECK_CFG:      next_st.rdata = st.regs.tx_check_code_cfg;
        default:             next_st.rdata = 8'h00;
      endcase
    end

    // serial pin synchroniser
    next_st.sync_a = external_serial_input_in;
    next_st.sync_b = st.sync_a;

    // frame sequencer
    case (st.state)
      ST_IDLE: begin
        next_st.envelope = 1'b0;
        if (take_byte) begin
          next_st.shift   = tx_byte_in;
          next_st.bit_cnt = 3'h0;
          next_st.crc     = check_preset(start_sel, width_sel, user_preset_in);
          next_st.ready   = 1'b0;
          next_st.state   = ST_DATA;
        end
      end
      ST_DATA: begin
        next_st.envelope = st.shift[0];
        next_st.crc      = check_step(st.crc, st.shift[0], width_sel);
        next_st.shift    = {1'b0, st.shift[7:1]};
        next_st.bit_cnt  = st.bit_cnt + 3'h1;
        next_st.ready    = (st.bit_cnt == 3'h6);
        if (st.bit_cnt == 3'h7) begin
          if (take_byte) begin
            next_st.shift = tx_byte_in;
          end else if (append_on && width_sel != 2'h3) begin
            next_st.crc_cnt = check_top(width_sel);
            next_st.state   = ST_CHECK;
          end else begin
            next_st.ready = 1'b1;
            next_st.state = ST_IDLE;
          end
        end
      end
      ST_CHECK: begin
        next_st.envelope = st.crc[st.crc_cnt] ^ complement;
        next_st.crc_cnt  = st.crc_cnt - 4'h1;
        if (st.crc_cnt == 4'h0) begin
          next_st.ready = 1'b1;
          next_st.state = ST_IDLE;
        end
      end
      default: begin
        next_st.ready = 1'b1;
        next_st.state = ST_IDLE;
      end
    endcase

    // extra modulation after each modulation onset
    next_st.mod_prev = mod_now;
    if (mod_now && !st.mod_prev) begin
      next_st.os_cnt = st.regs.modulation_ctrl[`MSB_EXTRA_MOD:`LSB_EXTRA_MOD];
    end else if (st.os_cnt != 4'h0) begin
      next_st.os_cnt = st.os_cnt - 4'h1;
    end

    // amplitude reduction, overridden by full carrier
    case (st.regs.carrier_amplitude_ctrl[`MSB_CARRIER_TRIM:`LSB_CARRIER_TRIM])
      2'h0:    next_st.drop_mv = `DROP_MV_0;
      2'h1:    next_st.drop_mv = `DROP_MV_1;
      2'h2:    next_st.drop_mv = `DROP_MV_2;
      default: next_st.drop_mv = `DROP_MV_3;
    endcase
    if (st.regs.modulation_ctrl[`BIT_CARRIER_FULL]) begin
      next_st.drop_mv = 10'h000;
    end

    next_st.pins      = next_pin;
    next_st.busy      = (next_st.state != ST_IDLE);
    next_st.os_active = (next_st.os_cnt != 4'h0);
  end

  // both pins share the enable, each with its own inversion
  generate
    for (genvar p = 0; p < 2; p++) begin : g_pin
      assign next_pin[p] = st.regs.driver_mode_ctrl[`BIT_PINS_ON] & (mod_now ^ pin_inv[p]);
    end
  endgenerate

  always_ff @(posedge ref_clk_in) begin
    if (rst_in) begin
      st       <= '0;
      st.ready <= 1'b1;
      st.state <= ST_IDLE;
      st.regs  <= {5{`RST_REG}};
    end else begin
      st <= next_st;
    end
  end

  assign reg_rdata_out             = st.rdata;
  assign tx_byte_ready_out         = st.ready;
  assign tx_busy_out               = st.busy;
  assign antenna_out_a_out         = st.pins[0];
  assign antenna_out_b_out         = st.pins[1];
  assign driver_output_style_out   = st.regs.driver_mode_ctrl[`MSB_OUTPUT_STYLE:0];
  assign carrier_full_out          = st.regs.modulation_ctrl[`BIT_CARRIER_FULL];
  assign carrier_drop_mv_out       = st.drop_mv;
  assign residual_carrier_out      = st.regs.carrier_amplitude_ctrl[`MSB_RESIDUAL:0];
  assign extra_mod_length_out      = st.regs.modulation_ctrl[`MSB_EXTRA_MOD:`LSB_EXTRA_MOD];
  assign overshoot_active_out      = st.os_active;
  assign first_phase_overshoot_out = st.regs.load_overshoot_ctrl[`MSB_FIRST_PHASE:`LSB_FIRST_PHASE];
  assign load_current_trim_out     = st.regs.load_overshoot_ctrl[`MSB_LOAD_TRIM:0];

  default clocking cb @(posedge ref_clk_in); endclocking
  default disable iff (rst_in);

  a_pin_b_invert: assert property (!reg_wr_in |=> antenna_out_b_out ==
    ($past(st.regs.driver_mode_ctrl[`BIT_PINS_ON]) & ($past(mod_now) ^ $past(pin_inv[1]))))
    else $error("second pin level wrong");
  a_pin_a_invert: assert property (antenna_out_a_out == $past(next_pin[0]) ##0
    (!st.regs.driver_mode_ctrl[`BIT_OUT1_INVERT] || antenna_out_a_out != $past(mod_now) ||
     !$past(st.regs.driver_mode_ctrl[`BIT_PINS_ON]) || $changed(st.regs.driver_mode_ctrl)))
    else $error("first pin inversion wrong");
  a_pins_disabled: assert property (!st.regs.driver_mode_ctrl[`BIT_PINS_ON] && !reg_wr_in
    |=> !antenna_out_a_out && !antenna_out_b_out)
    else $error("pins driven while disabled");
  a_drop_halfvolt: assert property (st.regs.carrier_amplitude_ctrl[7:6] == 2'h2 && !carrier_full_out
    && !reg_wr_in |=> carrier_drop_mv_out == `DROP_MV_2)
    else $error("amplitude drop wrong");
  a_full_carrier: assert property (carrier_full_out && !reg_wr_in |=> carrier_drop_mv_out == 10'h000)
    else $error("full carrier not honoured");
  a_overshoot_load: assert property (mod_now && !st.mod_prev |=>
    st.os_cnt == $past(st.regs.modulation_ctrl[`MSB_EXTRA_MOD:`LSB_EXTRA_MOD]))
    else $error("extra modulation length wrong");
  a_source_none: assert property (st.regs.modulation_ctrl[2:0] == 3'h0 |-> !mod_now)
    else $error("modulation without source");
  a_no_append: assert property (st.state == ST_DATA && st.bit_cnt == 3'h7 && !take_byte && !append_on
    |=> st.state == ST_IDLE)
    else $error("code appended while disabled");
  a_rsvd_width: assert property (width_sel == 2'h3 |-> ##1 st.state != ST_CHECK || $past(st.state) == ST_CHECK)
    else $error("reserved width appended");
  a_frame_preset: assert property (st.state == ST_IDLE && take_byte
    |=> st.crc == check_preset($past(start_sel), $past(width_sel), $past(user_preset_in)))
    else $error("start value not loaded");
  a_lsb_first: assert property (st.state == ST_DATA |=> st.envelope == $past(st.shift[0]))
    else $error("data bit order wrong");

  a_residual_field: assert property (reg_wr_in && reg_addr_in == `OFF_CARRIER_AMP |=>
    st.regs.carrier_amplitude_ctrl[5:0] == {1'b0, $past(reg_wdata_in[4:0])})
    else $error("residual carrier field wrong");
  a_amp_read: assert property (reg_rd_in && reg_addr_in == `OFF_CARRIER_AMP |=> !reg_rdata_out[5])
    else $error("reserved amplitude bit read back");
  a_extra_length: assert property (reg_wr_in && reg_addr_in == `OFF_MOD_CTRL |=>
    extra_mod_length_out == $past(reg_wdata_in[7:4]))
    else $error("extra modulation field wrong");
  a_overshoot_count: assert property (st.os_cnt != 4'h0 && !(mod_now && !st.mod_prev) |=>
    st.os_cnt == $past(st.os_cnt) - 4'h1)
    else $error("overshoot count wrong");
  a_full_flag: assert property (reg_wr_in && reg_addr_in == `OFF_MOD_CTRL |=>
    carrier_full_out == $past(reg_wdata_in[`BIT_CARRIER_FULL]))
    else $error("full carrier flag wrong");
  a_drop_smallest: assert property (st.regs.carrier_amplitude_ctrl[7:6] == 2'h0 && !carrier_full_out |=>
    carrier_drop_mv_out == `DROP_MV_0)
    else $error("smallest amplitude drop wrong");
  a_pins_enabled: assert property (st.regs.driver_mode_ctrl[7:6] == 2'h0 && st.regs.driver_mode_ctrl[3] |=>
    antenna_out_a_out == $past(mod_now) && antenna_out_b_out == $past(mod_now))
    else $error("enabled pins do not follow modulation");
  a_envelope_source: assert property (st.regs.modulation_ctrl[2:0] == 3'h1 |-> mod_now == st.envelope)
    else $error("envelope not selected");
  a_serial_source: assert property (st.regs.modulation_ctrl[2:0] == 3'h6 |-> mod_now == !st.sync_b)
    else $error("inverted serial not selected");
  a_first_phase: assert property (reg_wr_in && reg_addr_in == `OFF_LOAD_OVERSHOOT |=>
    first_phase_overshoot_out == $past(reg_wdata_in[7:4]))
    else $error("first phase overshoot wrong");
  a_load_trim: assert property (reg_wr_in && reg_addr_in == `OFF_LOAD_OVERSHOOT |=>
    load_current_trim_out == $past(reg_wdata_in[3:0]))
    else $error("load current trim wrong");
  a_ready_idle: assert property (st.state == ST_IDLE |-> tx_byte_ready_out)
    else $error("idle without ready");
  a_code_complement: assert property (st.state == ST_CHECK |=>
    st.envelope == $past(st.crc[st.crc_cnt] ^ complement))
    else $error("appended code bit wrong");
  a_code5_length: assert property (st.state == ST_DATA && st.bit_cnt == 3'h7 && !take_byte && append_on &&
    width_sel == 2'h0 |=> st.state == ST_CHECK ##5 st.state == ST_IDLE)
    else $error("five bit code length wrong");
  a_code8_length: assert property (st.state == ST_DATA && st.bit_cnt == 3'h7 && !take_byte && append_on &&
    width_sel == 2'h1 |=> st.state == ST_CHECK ##8 st.state == ST_IDLE)
    else $error("eight bit code length wrong");
  a_code16_length: assert property (st.state == ST_DATA && st.bit_cnt == 3'h7 && !take_byte && append_on &&
    width_sel == 2'h2 |=> st.state == ST_CHECK ##16 st.state == ST_IDLE)
    else $error("sixteen bit code length wrong");
  a_check_cfg: assert property (reg_wr_in && reg_addr_in == `OFF_CHECK_CFG |=>
    st.regs.tx_check_code_cfg == {1'b0, $past(reg_wdata_in[6:0])})
    else $error("check code configuration wrong");
  a_preset_ones: assert property (st.state == ST_IDLE && take_byte && start_sel == 3'h7 &&
    width_sel == 2'h2 |=> st.crc == `PRESET16_7)
    else $error("all ones start value wrong");
  a_preset_user: assert property (st.state == ST_IDLE && take_byte && start_sel == 3'h6 &&
    width_sel == 2'h2 |=> st.crc == $past(user_preset_in))
    else $error("stored start value wrong");
  a_ready_last_bit: assert property (st.state == ST_DATA |-> tx_byte_ready_out == (st.bit_cnt == 3'h7))
    else $error("ready outside last bit");
  a_idle_silent: assert property (st.state == ST_IDLE && $past(st.state) == ST_IDLE |-> !st.envelope)
    else $error("envelope active while idle");
  a_code_step: assert property (st.state == ST_DATA |=>
    st.crc == check_step($past(st.crc), $past(st.shift[0]), $past(width_sel)))
    else $error("check code step wrong");
  a_busy_state: assert property (tx_busy_out == (st.state != ST_IDLE))
    else $error("busy flag wrong");

endmodule : tx_crc_and_modulation_ctrl

`default_nettype wire

// [verif/card_side_model.sv]
// card side of the antenna: records the first antenna pin, drives the serial modulation pin
// assumes the bench chooses the serial level and reads the recorded trail
`timescale 1ns/1ns
`default_nettype none

module card_side_model (
  input  wire logic        ref_clk_in,
  input  wire logic        antenna_a_in,
  input  wire logic        serial_level_in,
  output logic             serial_out,
  output logic      [63:0] trail_out
);
  // the serial pin is driven at all times, so it never floats
  assign serial_out = serial_level_in;

  // newest pin sample lands in bit 0; bytes arrive lsb first, then the code
  always_ff @(posedge ref_clk_in) begin
    trail_out <= {trail_out[62:0], antenna_a_in};
  end
endmodule : card_side_model

`default_nettype wire

// [verif/tx_crc_and_modulation_ctrl_test.sv]
// self-checking bench of the transmit control block
// assumes the card side model and the block's defines header
`timescale 1ns/1ns
`include "tx_crc_defines.svh"
`default_nettype none
`define CHK(nm, e, g) begin n_checks++; if ((g) !== (e)) begin failures++; \
  $display("MISMATCH %s exp %h got %h", nm, e, g); end end

module tx_crc_and_modulation_ctrl_test
  import tx_crc_pkg::*;
;
  logic        ref_clk_in = 1'b0;
  logic        rst_in = 1'b1;
  logic [7:0]  addr = 8'h00, wdata = 8'h00, tbyte = 8'h00, rdata;
  logic        wr = 1'b0, rd = 1'b0, bvalid = 1'b0, serial_level = 1'b0;
  logic [15:0] user_preset = 16'h5a3c;
  logic        ready, busy, ant_a, ant_b, full, os_act, serial;
  logic [2:0]  style;
  logic [9:0]  drop;
  logic [4:0]  resid;
  logic [3:0]  extra, first, trim;
  logic [63:0] trail;
  int          failures = 0;
  int          n_checks = 0;

  always #5 ref_clk_in = ~ref_clk_in;

  tx_crc_and_modulation_ctrl u_tx_crc_and_modulation_ctrl (
    .ref_clk_in(ref_clk_in), .rst_in(rst_in), .reg_addr_in(addr), .reg_wdata_in(wdata),
    .reg_wr_in(wr), .reg_rd_in(rd), .reg_rdata_out(rdata), .tx_byte_in(tbyte),
    .tx_byte_valid_in(bvalid), .tx_byte_ready_out(ready), .tx_busy_out(busy),
    .user_preset_in(user_preset), .external_serial_input_in(serial),
    .antenna_out_a_out(ant_a), .antenna_out_b_out(ant_b), .driver_output_style_out(style),
    .carrier_full_out(full), .carrier_drop_mv_out(drop), .residual_carrier_out(resid),
    .extra_mod_length_out(extra), .overshoot_active_out(os_act),
    .first_phase_overshoot_out(first), .load_current_trim_out(trim));

  card_side_model u_card_side_model (
    .ref_clk_in(ref_clk_in), .antenna_a_in(ant_a), .serial_level_in(serial_level),
    .serial_out(serial), .trail_out(trail));

  task automatic end_sim;
    if (failures == 0 && n_checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : end_sim

  task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
    @(posedge ref_clk_in);
    addr  <= a;
    wdata <= d;
    wr    <= 1'b1;
    @(posedge ref_clk_in);
    wr <= 1'b0;
  endtask : wr_reg

  task automatic rd_chk(input logic [7:0] a, input logic [7:0] e);
    @(posedge ref_clk_in);
    addr <= a;
    rd   <= 1'b1;
    @(posedge ref_clk_in);
    rd <= 1'b0;
    @(negedge ref_clk_in);
    `CHK("reg read", e, rdata)
  endtask : rd_chk

  task automatic t_regs;
    logic [7:0] offs[5] = '{8'h28, 8'h29, 8'h2a, 8'h2b, 8'h2c};
    logic [7:0] msk[5] = '{8'hcf, 8'hdf, 8'hff, 8'hff, 8'h7f};
    logic [2:0] sty[6] = '{3'h0, 3'h1, 3'h2, 3'h4, 3'h5, 3'h7};
    for (int i = 0; i < 5; i++) rd_chk(offs[i], 8'h00);
    for (int i = 0; i < 5; i++) wr_reg(offs[i], 8'hff);
    for (int i = 0; i < 5; i++) rd_chk(offs[i], msk[i]);
    @(negedge ref_clk_in);
    `CHK("residual", 5'h1f, resid)
    `CHK("extra len", 4'hf, extra)
    `CHK("first phase", 4'hf, first)
    `CHK("load trim", 4'hf, trim)
    wr_reg(8'h2b, 8'h5a);
    @(negedge ref_clk_in);
    `CHK("split load", 8'h5a, {first, trim})
    wr_reg(8'h2d, 8'hff);
    rd_chk(8'h2d, 8'h00);
    foreach (sty[i]) begin
      wr_reg(8'h28, {5'h00, sty[i]});
      @(negedge ref_clk_in);
      `CHK("style", sty[i], style)
    end
  endtask : t_regs

  task automatic t_amp;
    logic [9:0] mv[4] = '{10'h064, 10'h0fa, 10'h1f4, 10'h3e8};
    wr_reg(8'h2a, 8'h00);
    for (int c = 0; c < 4; c++) begin
      wr_reg(8'h29, {c[1:0], 6'h15});
      repeat (2) @(negedge ref_clk_in);
      `CHK("drop", mv[c], drop)
    end
    wr_reg(8'h2a, 8'h08);
    repeat (2) @(negedge ref_clk_in);
    `CHK("drop full", 10'h000, drop)
    `CHK("full", 1'b1, full)
  endtask : t_amp

  task automatic t_pins;
    // driver mode, modulation control, then serial level and expected pins a, b
    logic [19:0] tab[9] = '{20'h00040, 20'h48002, 20'h88001, 20'h08043, 20'h08027,
                            20'h08020, 20'h08064, 20'h08010, 20'hc8003};
    foreach (tab[i]) begin
      wr_reg(8'h28, tab[i][19:12]);
      serial_level <= tab[i][2];
      wr_reg(8'h2a, tab[i][11:4]);
      repeat (6) @(negedge ref_clk_in);
      `CHK("pin a", tab[i][1], ant_a)
      `CHK("pin b", tab[i][0], ant_b)
    end
  endtask : t_pins

  task automatic t_overshoot;
    int n;
    n = 0;
    wr_reg(8'h2a, 8'h32);
    repeat (20) @(posedge ref_clk_in);
    serial_level <= 1'b1;
    repeat (20) begin
      @(negedge ref_clk_in);
      n += (os_act === 1'b1);
    end
    `CHK("overshoot len", 4'h3, n[3:0])
    @(posedge ref_clk_in);
    serial_level <= 1'b0;
  endtask : t_overshoot

  task automatic t_frame(input int w, input int p, input logic inv, input logic app);
    logic [15:0] crc, poly, mask, data;
    logic [47:0] exp, got;
    logic        fb;
    int          cw, i;
    data = 16'h5ab3;
    cw   = (w == 0) ? 5 : (w == 1) ? 8 : 16;
    poly = (w == 0) ? `POLY_5 : (w == 1) ? `POLY_8 : `POLY_16;
    mask = 16'hffff >> (16 - cw);
    case (p)
      0: crc = 16'h0000;
      1: crc = (w == 2) ? 16'h6363 : 16'h0012;
      2: crc = (w == 1) ? 16'h00bf : 16'ha671;
      3: crc = (w == 1) ? 16'h00fd : 16'hfffe;
      6: crc = user_preset;
      default: crc = 16'hffff;
    endcase
    crc = crc & mask;
    exp = '0;
    for (int k = 0; k < 16; k++) begin
      exp[47 - k] = data[k];
      fb  = data[k] ^ crc[cw - 1];
      crc = (crc << 1) & mask;
      if (fb) crc = crc ^ poly;
    end
    if (inv) crc = ~crc & mask;
    for (int k = 0; k < cw; k++) if (app && w != 3) exp[31 - k] = crc[cw - 1 - k];
    wr_reg(8'h28, 8'h08);
    wr_reg(8'h2a, 8'h01);
    wr_reg(8'h2c, {1'b0, p[2:0], w[1:0], inv, app});
    repeat (70) @(posedge ref_clk_in);
    bvalid <= 1'b1;
    tbyte  <= data[7:0];
    for (int b = 0; b < 2; b++) begin
      i = 0;
      do begin
        @(negedge ref_clk_in);
        i++;
      end while (ready !== 1'b1 && i < 50);
      @(posedge ref_clk_in);
      tbyte <= data[15:8];
    end
    bvalid <= 1'b0;
    i = 0;
    do begin
      @(negedge ref_clk_in);
      i++;
    end while (busy !== 1'b0 && i < 100);
    repeat (6) @(negedge ref_clk_in);
    i = 63;
    while (i > 0 && trail[i] !== 1'b1) i--;
    for (int k = 0; k < 48; k++) got[47 - k] = (i - k >= 0) ? trail[i - k] : 1'b0;
    `CHK("frame bits", exp, got)
    `CHK("busy after frame", 1'b0, busy)
    `CHK("ready after frame", 1'b1, ready)
  endtask : t_frame

  initial begin
    static int pres[6] = '{0, 1, 2, 3, 6, 7};
    repeat (6) @(posedge ref_clk_in);
    rst_in <= 1'b0;
    t_regs();
    t_amp();
    t_pins();
    t_overshoot();
    for (int w = 0; w < 3; w++)
      foreach (pres[j]) if (w != 0 || pres[j] < 2 || pres[j] > 3) t_frame(w, pres[j], j[0], 1'b1);
    t_frame(2, 7, 1'b0, 1'b0);
    t_frame(3, 7, 1'b0, 1'b1);
    end_sim();
  end

  initial begin
    repeat (20000) @(posedge ref_clk_in);
    failures++;
    end_sim();
  end
endmodule : tx_crc_and_modulation_ctrl_test

`default_nettype wire
